/* File: design/event_user_routing_status.sv */
`timescale 1ns/1ps
`include "evr_consts.svh"

module event_user_routing_status #(
  parameter int NUM_SINKS = 29,
  parameter int NUM_CHANS = 12
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  // Register bus
  input  wire evr_pkg::bus_req_s      i_bus,
  output logic [31:0]                 o_rdata,
  // Channel side
  input  wire logic [NUM_CHANS-1:0]   i_chan_event,
  input  wire evr_pkg::path_t [NUM_CHANS-1:0] i_chan_path,
  // Consumer side
  input  wire logic [NUM_SINKS-1:0]   i_sink_ready,
  input  wire logic [NUM_SINKS-1:0]   i_sink_ack,
  output logic [NUM_SINKS-1:0]        o_sink_event,
  // Interrupt
  output logic                        o_irq
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Whether a consumer index admits a given channel path
  function automatic logic path_ok(input logic [4:0] idx, input evr_pkg::path_t p);
    logic ok;
    ok = 1'b0;
    if (idx <= `EVR_RESYNC_LAST) begin
      ok = (p == evr_pkg::PATH_RESYNC);
    end else if (idx <= `EVR_ANY_LAST) begin
      ok = (p == evr_pkg::PATH_RESYNC) || (p == evr_pkg::PATH_SYNC) ||
           (p == evr_pkg::PATH_ASYNC);
    end else if (idx <= `EVR_IDX_LAST) begin
      ok = (p == evr_pkg::PATH_ASYNC);
    end
    return ok;
  endfunction

  // Codes 1 to 12 name a channel; zero and reserved codes name none
  function automatic logic code_ok(input logic [4:0] code);
    return (code != 5'h00) && (code <= `EVR_CHAN_CODE_LAST);
  endfunction

  // Code n+1 names channel n
  function automatic logic attached(input logic [4:0] code, input int ch);
    logic hit;
    hit = 1'b0;
    if (code_ok(code)) begin
      hit = (code == 5'(ch + 1));
    end
    return hit;
  endfunction

  // Consumer indices above the last one are reserved
  function automatic logic idx_ok(input logic [4:0] idx);
    return idx <= `EVR_IDX_LAST;
  endfunction

  // Whether the channel named by a code fires now on a path the consumer takes
  function automatic logic fires(input logic [4:0]                     code,
                                 input logic [4:0]                     idx,
                                 input logic [NUM_CHANS-1:0]           ev,
                                 input evr_pkg::path_t [NUM_CHANS-1:0] path);
    logic hit;
    int   ch;
    hit = 1'b0;
    ch  = 0;
    if (code_ok(code)) begin
      ch  = int'(code) - 1;
      hit = ev[ch] && path_ok(idx, path[ch]);
    end
    return hit;
  endfunction

  // Place ready and pending bits; reserved bits stay zero
  function automatic logic [31:0] pack_state(input logic [11:0] p, input logic [11:0] r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EVR_READY_LSB +: `EVR_LO_CHANS]    = r[7:0];
    w[`EVR_READY_HI_LSB +: `EVR_HI_CHANS] = r[11:8];
    w[`EVR_PEND_LSB +: `EVR_LO_CHANS]     = p[7:0];
    w[`EVR_PEND_HI_LSB +: `EVR_HI_CHANS]  = p[11:8];
    return w;
  endfunction

  // Pull the twelve pending bits back out of a status word
  function automatic logic [11:0] state_pend(input logic [31:0] w);
    return {w[`EVR_PEND_HI_LSB +: `EVR_HI_CHANS], w[`EVR_PEND_LSB +: `EVR_LO_CHANS]};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************

  evr_pkg::route_word_s wr_word;
  logic                 route_wr;
  logic                 index_wr;
  logic                 mask_wr;
  logic                 stat_rd;

  // Full word and byte writes are told apart by the byte enables
  assign wr_word  = i_bus.wdata[15:0];
  assign route_wr = i_bus.wr && (i_bus.addr == `EVR_OFS_ROUTE) && (i_bus.wbe == 2'b11);
  assign index_wr = i_bus.wr && (i_bus.addr == `EVR_OFS_ROUTE) && (i_bus.wbe == 2'b01);
  assign mask_wr  = i_bus.wr && (i_bus.addr == `EVR_OFS_IRQ_MASK) && i_bus.wbe[0];
  assign stat_rd  = i_bus.rd && (i_bus.addr == `EVR_OFS_IRQ_STAT);

  // ****************************************
  // Routing table
  // ****************************************

  logic [4:0] route [NUM_SINKS];
  logic [4:0] next_route [NUM_SINKS];
  logic [4:0] sel_idx;
  logic [4:0] next_sel_idx;
  logic       wr_reject;

  always_comb begin
    wr_reject    = 1'b0;
    next_sel_idx = sel_idx;
    for (int u = 0; u < NUM_SINKS; u++) begin
      next_route[u] = route[u];
    end
    if (route_wr) begin
      // Whole routing word: index and channel land together
      if (idx_ok(wr_word.sink_idx) && wr_word.chan_code <= `EVR_CHAN_CODE_LAST) begin
        next_route[wr_word.sink_idx] = wr_word.chan_code;
        next_sel_idx                 = wr_word.sink_idx;
      end else begin
        wr_reject = 1'b1;
      end
    end else if (index_wr) begin
      // Byte write only points the read-back index
      if (idx_ok(wr_word.sink_idx)) begin
        next_sel_idx = wr_word.sink_idx;
      end else begin
        wr_reject = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int u = 0; u < NUM_SINKS; u++) begin
        route[u] <= `EVR_ROUTE_RESET;
      end
      sel_idx <= 5'h00;
    end else begin
      for (int u = 0; u < NUM_SINKS; u++) begin
        route[u] <= next_route[u];
      end
      sel_idx <= next_sel_idx;
    end
  end

  // ****************************************
  // Event delivery
  // ****************************************

  logic [NUM_SINKS-1:0] busy;
  logic [NUM_SINKS-1:0] next_busy;
  logic [NUM_SINKS-1:0] next_sink_event;

  always_comb begin
    next_sink_event = '0;
    next_busy       = '0;
    for (int u = 0; u < NUM_SINKS; u++) begin
      next_sink_event[u] = fires(route[u], 5'(u), i_chan_event, i_chan_path);
      // A new event outweighs an acknowledge in the same cycle
      next_busy[u] = (busy[u] & ~i_sink_ack[u]) | next_sink_event[u];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy         <= '0;
      o_sink_event <= '0;
    end else begin
      busy         <= next_busy;
      o_sink_event <= next_sink_event;
    end
  end

  // ****************************************
  // Channel status
  // ****************************************

  logic [NUM_CHANS-1:0] pend;
  logic [NUM_CHANS-1:0] rdy;
  logic [31:0]          chan_state;
  logic [31:0]          next_chan_state;

  always_comb begin
    pend = '0;
    rdy  = '1;
    for (int c = 0; c < NUM_CHANS; c++) begin
      for (int u = 0; u < NUM_SINKS; u++) begin
        if (attached(route[u], c)) begin
          pend[c] = pend[c] | next_busy[u];
          rdy[c]  = rdy[c] & i_sink_ready[u];
        end
      end
    end
    next_chan_state = pack_state(pend, rdy);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_state <= `EVR_STATE_RESET;
    end else begin
      chan_state <= next_chan_state;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************

  logic [NUM_CHANS-1:0] went_idle;
  logic [12:0]          irq_set;
  logic [12:0]          irq_flags;
  logic [12:0]          next_irq_flags;
  logic [12:0]          irq_mask;
  logic [12:0]          next_irq_mask;
  logic                 next_irq;

  always_comb begin
    // A channel falling idle is an interrupt event
    went_idle      = state_pend(chan_state) & ~pend;
    irq_set        = {wr_reject, went_idle};
    next_irq_mask  = irq_mask;
    next_irq_flags = irq_flags;
    if (mask_wr) begin
      next_irq_mask = i_bus.wdata[12:0];
    end
    if (stat_rd) begin
      next_irq_flags = `EVR_FLAGS_RESET;
    end
    // Setting wins over the read clear
    next_irq_flags = next_irq_flags | irq_set;
    next_irq       = |(next_irq_flags & next_irq_mask);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_flags <= `EVR_FLAGS_RESET;
      irq_mask  <= `EVR_FLAGS_RESET;
      o_irq     <= 1'b0;
    end else begin
      irq_flags <= next_irq_flags;
      irq_mask  <= next_irq_mask;
      o_irq     <= next_irq;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `EVR_OFS_ROUTE: begin
          next_rdata[`EVR_CHAN_MSB:`EVR_CHAN_LSB] = route[sel_idx];
          next_rdata[`EVR_IDX_MSB:`EVR_IDX_LSB]   = sel_idx;
        end
        `EVR_OFS_STATE: begin
          next_rdata = chan_state;
        end
        `EVR_OFS_IRQ_STAT: begin
          next_rdata[12:0] = irq_flags;
        end
        `EVR_OFS_IRQ_MASK: begin
          next_rdata[12:0] = irq_mask;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule

/* File: design/evr_consts.svh */
// How it works
// - Five-bit channel field picks consumer's channel
// - Code n+1 selects channel n; codes above 12 reserved
// - Code zero connects consumer to no channel
// - Index field picks consumer for writes and reads
// - Index range limits accepted path type
// - Reserved bits read zero, written zero
// - Pending flag while attached consumers unhandled
// - Ready flag when all attached consumers ready
// - Byte write of index, then read returns route
`ifndef EVR_CONSTS_SVH
`define EVR_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define EVR_OFS_ROUTE      8'h08
`define EVR_OFS_STATE      8'h0C
`define EVR_OFS_IRQ_STAT   8'h20
`define EVR_OFS_IRQ_MASK   8'h24

// ****************************************
// Field positions and limits
// ****************************************
`define EVR_IDX_LSB        0
`define EVR_IDX_MSB        4
`define EVR_CHAN_LSB       8
`define EVR_CHAN_MSB       12
`define EVR_IDX_LAST       5'h1C
`define EVR_CHAN_CODE_LAST 5'h0C
`define EVR_RESYNC_LAST    5'h03
`define EVR_ANY_LAST       5'h16
`define EVR_READY_LSB      0
`define EVR_READY_HI_LSB   16
`define EVR_PEND_LSB       8
`define EVR_PEND_HI_LSB    24
`define EVR_LO_CHANS       8
`define EVR_HI_CHANS       4

// ****************************************
// Reset values
// ****************************************
`define EVR_STATE_RESET    32'h000F00FF
`define EVR_ROUTE_RESET    5'h00
`define EVR_FLAGS_RESET    13'h0000
`define EVR_REJECT_BIT     12

`endif

/* File: design/evr_pkg.sv */
package evr_pkg;

  // Path type codes a channel may carry
  typedef logic [1:0] path_t;
  localparam path_t PATH_SYNC   = 2'h0;
  localparam path_t PATH_RESYNC = 2'h1;
  localparam path_t PATH_ASYNC  = 2'h2;

  // Layout of the consumer routing word
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic [4:0] chan_code;
    logic [2:0] rsvd_lo;
    logic [4:0] sink_idx;
  } route_word_s;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  wbe;
    logic        wr;
    logic        rd;
  } bus_req_s;

endpackage

/* File: verification/evr_sinks.sv */
`timescale 1ns/1ps
module evr_sinks #(
  parameter int N = 29
) (
  // Clock, reset and consumer side
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  input  wire logic [N-1:0] i_event,
  input  wire logic [N-1:0] i_hold,
  output logic      [N-1:0] o_ready,
  output logic      [N-1:0] o_ack
);
  logic [N-1:0] pend;
  // A held consumer is not ready and does not acknowledge
  assign o_ready = ~i_hold;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend  <= '0;
      o_ack <= '0;
    end else begin
      pend  <= (pend & ~o_ack) | i_event;
      o_ack <= pend & ~o_ack & ~i_hold;
    end
  end
endmodule

/* File: verification/evr_sva.sv */
`timescale 1ns/1ps
`include "evr_consts.svh"
module evr_sva #(
  parameter int NUM_SINKS = 29,
  parameter int NUM_CHANS = 12
) (
  // Watched ports
  input wire logic                           i_ref_clk,
  input wire logic                           i_nrst,
  input wire evr_pkg::bus_req_s              i_bus,
  input wire logic [31:0]                    o_rdata,
  input wire logic [NUM_CHANS-1:0]           i_chan_event,
  input wire evr_pkg::path_t [NUM_CHANS-1:0] i_chan_path,
  input wire logic [NUM_SINKS-1:0]           i_sink_ready,
  input wire logic [NUM_SINKS-1:0]           o_sink_event
);
  logic [NUM_CHANS-1:0] ev_rs, ev_as, ev_ok;
  always_comb begin
    for (int c = 0; c < NUM_CHANS; c++) begin
      ev_rs[c] = i_chan_event[c] && i_chan_path[c] == evr_pkg::PATH_RESYNC;
      ev_as[c] = i_chan_event[c] && i_chan_path[c] == evr_pkg::PATH_ASYNC;
      ev_ok[c] = i_chan_event[c] && i_chan_path[c] != 2'h3;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  route_rsvd_a: assert property ($past(i_bus.rd && i_bus.addr == `EVR_OFS_ROUTE)
    |-> o_rdata[31:13] == 19'h0 && o_rdata[7:5] == 3'h0) else $error("route reserved bits");
  state_rsvd_a: assert property ($past(i_bus.rd && i_bus.addr == `EVR_OFS_STATE)
    |-> o_rdata[31:28] == 4'h0 && o_rdata[23:20] == 4'h0) else $error("state reserved bits");
  ready_all_a: assert property ($past(i_bus.rd && i_bus.addr == `EVR_OFS_STATE)
    && $past(&i_sink_ready, 2) |-> o_rdata[7:0] == 8'hFF && o_rdata[19:16] == 4'hF)
    else $error("ready flags low with all ready");
  event_cause_a: assert property (|o_sink_event |-> |$past(ev_ok))
    else $error("event without channel event");
  resync_only_a: assert property (|o_sink_event[3:0] |-> |$past(ev_rs))
    else $error("low sinks got non resync event");
  any_path_a: assert property (|o_sink_event[22:4] |-> |$past(ev_ok))
    else $error("mid sinks got reserved path event");
  async_only_a: assert property (|o_sink_event[NUM_SINKS-1:23] |-> |$past(ev_as))
    else $error("high sinks got non async event");
  cover property (|o_sink_event);
  cover property (!(&i_sink_ready));
  cover property ($past(i_bus.rd) && o_rdata != 32'h0);
endmodule
bind event_user_routing_status evr_sva #(.NUM_SINKS(NUM_SINKS), .NUM_CHANS(NUM_CHANS)) i_sva (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_chan_event(i_chan_event), .i_chan_path(i_chan_path), .i_sink_ready(i_sink_ready),
  .o_sink_event(o_sink_event));

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "evr_consts.svh"
module tb;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  evr_pkg::bus_req_s     bus = '0;
  logic [31:0]           rdata;
  logic [11:0]           ev = '0;
  evr_pkg::path_t [11:0] path = '0;
  logic [28:0]           rdy, ack, sev, hold = '0;
  logic                  irq;
  logic [7:0]            su [3] = '{8'h00, 8'h0A, 8'h1C};
  logic [2:0]            ok [3] = '{3'b010, 3'b111, 3'b100};
  int                    n_errors = 0;
  int                    n_compared = 0;
  always #2.5 clk = ~clk;
  event_user_routing_status i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_bus(bus),
    .o_rdata(rdata), .i_chan_event(ev), .i_chan_path(path), .i_sink_ready(rdy),
    .i_sink_ack(ack), .o_sink_event(sev), .o_irq(irq));
  evr_sinks i_sinks (.i_ref_clk(clk), .i_nrst(nrst), .i_event(sev), .i_hold(hold),
    .o_ready(rdy), .o_ack(ack));
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk) bus <= '{addr: a, wdata: {16'h0, d}, wbe: be, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wbe: 2'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk($sformatf("read %h", a), e, rdata);
  endtask
  task automatic fire(input int c, input evr_pkg::path_t p, input int u, input logic e);
    @(posedge clk) ev[c] <= 1'b1;
    path[c] <= p;
    @(posedge clk) ev[c] <= 1'b0;
    #1 chk($sformatf("event to %0d", u), {31'h0, e}, {31'h0, sev[u]});
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc(`EVR_OFS_STATE, `EVR_STATE_RESET);
    wr(`EVR_OFS_ROUTE, 16'h0305, 2'h3);
    wr(`EVR_OFS_ROUTE, 16'h0D05, 2'h3);
    wr(`EVR_OFS_ROUTE, 16'h011D, 2'h3);
    wr(`EVR_OFS_ROUTE, 16'h0005, 2'h1);
    rdc(`EVR_OFS_ROUTE, 32'h0305);
    rdc(`EVR_OFS_IRQ_STAT, 32'h1000);
    $display("test routing done");
    wr(`EVR_OFS_IRQ_MASK, 16'h0004, 2'h3);
    @(posedge clk) hold[5] <= 1'b1;
    fire(2, evr_pkg::PATH_SYNC, 5, 1'b1);
    rdc(`EVR_OFS_STATE, 32'h000F04FB);
    @(posedge clk) hold[5] <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rdc(`EVR_OFS_IRQ_STAT, 32'h0004);
    rdc(`EVR_OFS_STATE, `EVR_STATE_RESET);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`EVR_OFS_ROUTE, 16'h0005, 2'h3);
    fire(2, evr_pkg::PATH_SYNC, 5, 1'b0);
    $display("test delivery done");
    foreach (su[i]) begin
      wr(`EVR_OFS_ROUTE, {8'h0C, su[i]}, 2'h3);
      for (int p = 0; p < 3; p++) fire(11, p[1:0], su[i], ok[i][p]);
    end
    wr(`EVR_OFS_ROUTE, 16'h000A, 2'h1);
    rdc(`EVR_OFS_ROUTE, 32'h0C0A);
    $display("test paths done");
    report_and_stop();
  end
endmodule
